// ===== hdl/standby_sense.v
// standby sensing sequencer, delta scaling, touch and noise-spike screening,
// and the five configuration registers behind the serial bus engine.
// assumes: the serial bus engine drives the register strobes on clk; the analog
// front end returns a magnitude count asynchronously; active thresholds on clk.
// standby_mode and noise_screen_disable come from logic on clk, so they are
// used without synchronisers.
`timescale 1ns/1ps
`include "standby_sense_defines.vh"

// Function
// - delta above noise threshold but not above touch threshold is a noise spike
// - noise screen disable lets every sample feed recalibration
// - two-bit shared code picks 25, 37.5, 50 or 62.5 percent
// - six enable bits choose inputs monitored in standby with standby settings
// - bit 7 selects summed rather than averaged delta; sum may overflow
// - three-bit field sets samples per measurement, 1 to 128, reset 8
// - all samples of one input taken back to back before the next
// - sample time 320us, 640us, 1.28ms or 2.56ms
// - cycle period 35, 70, 105 or 140 ms
// - sample enabled inputs at cycle start, then low power for the rest
// - cycle stretches when sampling outlasts the programmed period
// - sensitivity multiplier 128x down to 1x, halving per code, reset 32x
// - delta msb equals 64 raw counts at 128x, 8192 at 1x
// - standby settings touch only standby inputs, not active configuration
// - standby touch when delta exceeds seven-bit standby threshold, reset 40h
module standby_sense #(
  parameter integer SAMP_BASE_CYC  = `SAMP_T0_NS * `CLK_MHZ / 1000,
  parameter integer CYCLE_BASE_CYC = `CYCLE_T0_NS / 1000 * `CLK_MHZ,
  parameter integer RAW_W          = 16
) (
  input  wire              clk,
  input  wire              rst,
  input  wire              ce,
  input  wire              standby_mode,
  input  wire              noise_screen_disable,
  input  wire [41:0]       active_thresh,
  input  wire [7:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [7:0]        reg_rdata,
  input  wire [RAW_W-1:0]  afe_count,
  output reg               meas_start,
  output reg  [2:0]        meas_input,
  output reg               low_power,
  output reg               result_valid,
  output reg  [2:0]        result_input,
  output reg  [7:0]        result_delta,
  output reg  [5:0]        standby_touch,
  output reg               noise_spike,
  output reg               recal_use
);

  // state codes
  localparam [1:0] ST_IDLE  = 2'd0;
  localparam [1:0] ST_SAMP  = 2'd1;
  localparam [1:0] ST_CALC  = 2'd2;
  localparam [1:0] ST_REST  = 2'd3;

  // reset images, cut below to the width each register keeps
  localparam [7:0] RST_NC   = `RST_NOISE_THRESHOLD_CTRL;
  localparam [7:0] RST_EN   = `RST_STANDBY_INPUT_ENABLE;
  localparam [7:0] RST_CFG  = `RST_STANDBY_SENSING_CONFIG;
  localparam [7:0] RST_GAIN = `RST_STANDBY_SENSITIVITY;
  localparam [7:0] RST_THR  = `RST_STANDBY_THRESHOLD;

  //////////////////////////////////////////////////////////////////////////
  // registers; a write lands at once, so changing settings mid-cycle takes
  // effect on the very next sample, except the input enables, which are latched at cycle start
  reg  [1:0]       noise_pct_sel_r;
  reg  [5:0]       mon_en_r;
  reg  [7:0]       cfg_r;
  reg  [2:0]       gain_r;
  reg  [6:0]       sb_thr_r;

  // per-input standby enables, input 1 in bit 0
  wire             standby_mon_in1 = mon_en_r[0];
  wire             standby_mon_in2 = mon_en_r[1];
  wire             standby_mon_in3 = mon_en_r[2];
  wire             standby_mon_in4 = mon_en_r[3];
  wire             standby_mon_in5 = mon_en_r[4];
  wire             standby_mon_in6 = mon_en_r[5];
  wire [5:0]       mon_vec         = {standby_mon_in6, standby_mon_in5, standby_mon_in4,
                                      standby_mon_in3, standby_mon_in2, standby_mon_in1};

  // configuration fields
  wire             accumulate_not_average = cfg_r[`CFG_ACCUM_BIT];
  wire [2:0]       standby_sample_count   = cfg_r[`CFG_COUNT_MSB:`CFG_COUNT_LSB];
  wire [1:0]       standby_sample_period  = cfg_r[`CFG_SAMP_MSB:`CFG_SAMP_LSB];
  wire [1:0]       standby_cycle_period   = cfg_r[`CFG_CYC_MSB:`CFG_CYC_LSB];

  // read mux; unmapped offsets and unused upper bits read as zero
  reg  [7:0]       rdata_nxt;
  always @* begin
    rdata_nxt = 8'h00;
    if (reg_addr == `ADDR_NOISE_THRESHOLD_CTRL) begin
      rdata_nxt = {6'h00, noise_pct_sel_r};
    end else if (reg_addr == `ADDR_STANDBY_INPUT_ENABLE) begin
      rdata_nxt = {2'h0, mon_en_r};
    end else if (reg_addr == `ADDR_STANDBY_SENSING_CONFIG) begin
      rdata_nxt = cfg_r;
    end else if (reg_addr == `ADDR_STANDBY_SENSITIVITY) begin
      rdata_nxt = {5'h00, gain_r};
    end else if (reg_addr == `ADDR_STANDBY_THRESHOLD) begin
      rdata_nxt = {1'b0, sb_thr_r};
    end
  end

  // configuration registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      noise_pct_sel_r <= RST_NC[1:0];
      mon_en_r        <= RST_EN[5:0];
      cfg_r           <= RST_CFG;
      gain_r          <= RST_GAIN[2:0];
      sb_thr_r        <= RST_THR[6:0];
      reg_rdata       <= 8'h00;
    end else if (ce) begin
      // write decode; other offsets are ignored
      if (reg_wr) begin
        if (reg_addr == `ADDR_NOISE_THRESHOLD_CTRL) begin
          noise_pct_sel_r <= reg_wdata[`NOISE_PCT_MSB:`NOISE_PCT_LSB];
        end else if (reg_addr == `ADDR_STANDBY_INPUT_ENABLE) begin
          mon_en_r <= reg_wdata[`MON_MSB:`MON_LSB];
        end else if (reg_addr == `ADDR_STANDBY_SENSING_CONFIG) begin
          cfg_r <= reg_wdata;
        end else if (reg_addr == `ADDR_STANDBY_SENSITIVITY) begin
          gain_r <= reg_wdata[`GAIN_MSB:`GAIN_LSB];
        end else if (reg_addr == `ADDR_STANDBY_THRESHOLD) begin
          sb_thr_r <= reg_wdata[`THR_MSB:`THR_LSB];
        end
      end
      // read data stands from the edge after the strobe until the next read
      if (reg_rd) begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // analog count synchroniser; the count is held steady by the front end
  // for the whole sample period, so a bus-wide double flop is safe here
  reg  [RAW_W-1:0] afe_s1_r;
  reg  [RAW_W-1:0] afe_s2_r;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      afe_s1_r <= {RAW_W{1'b0}};
      afe_s2_r <= {RAW_W{1'b0}};
    end else if (ce) begin
      afe_s1_r <= afe_count;
      afe_s2_r <= afe_s1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // timing decode in clk cycles: a sample doubles per code step and the
  // cycle is the base period times code plus one; both bases are fixed at
  // build time through the parameters
  wire [31:0] samp_cyc  = SAMP_BASE_CYC;
  wire [31:0] cycle_cyc = CYCLE_BASE_CYC;
  wire [31:0] samp_len  = samp_cyc << standby_sample_period;
  wire [33:0] cyc_mul   = cycle_cyc * {30'h0, ({2'b00, standby_cycle_period} + 4'h1)};
  wire [31:0] cycle_len = cyc_mul[31:0];
  wire [7:0]  n_samples = 8'h01 << standby_sample_count;

  //////////////////////////////////////////////////////////////////////////
  // sequencer: idle, then per enabled input one pick cycle and its samples,
  // then rest with low_power until the cycle count runs out; a cycle whose
  // sampling outlasts the period rests a single cycle and starts again
  reg  [1:0]              state_r;
  // cycle and sample counters run in clk cycles; the sample-index counter counts samples
  reg  [31:0]             cyc_cnt_r;
  reg  [31:0]             samp_cnt_r;
  reg  [7:0]              samp_idx_r;
  reg  [2:0]              in_idx_r;
  reg  [RAW_W+7:0]        acc_r;
  reg  [5:0]              todo_r;

  // lowest pending enabled input; scanning down leaves the lowest set bit,
  // so inputs are taken in ascending order
  reg  [2:0]              next_in;
  reg                     next_ok;
  integer                 k;
  always @* begin
    next_in = 3'd0;
    next_ok = 1'b0;
    for (k = 5; k >= 0; k = k - 1) begin
      if (todo_r[k]) begin
        next_in = k[2:0];
        next_ok = 1'b1;
      end
    end
  end

  wire [RAW_W+7:0] acc_add = acc_r + {8'h00, afe_s2_r};

  // end of one sample, and of the last sample of the current input
  wire             samp_end  = (samp_cnt_r + 32'h1 >= samp_len);
  wire             samp_last = (samp_idx_r + 8'h01 == n_samples);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      cyc_cnt_r  <= 32'h0;
      samp_cnt_r <= 32'h0;
      samp_idx_r <= 8'h00;
      in_idx_r   <= 3'd0;
      acc_r      <= {(RAW_W+8){1'b0}};
      todo_r     <= 6'h00;
      meas_start <= 1'b0;
      meas_input <= 3'd0;
      low_power  <= 1'b0;
    end else if (ce) begin
      meas_start <= 1'b0;
      if (state_r != ST_IDLE) begin
        cyc_cnt_r <= cyc_cnt_r + 32'h1;
      end
      case (state_r)
        ST_IDLE: begin
          low_power <= 1'b0;
          // a cycle starts only when at least one input is enabled
          if (standby_mode && (mon_vec != 6'h00)) begin
            todo_r    <= mon_vec;
            cyc_cnt_r <= 32'h0;
            state_r   <= ST_CALC;
          end
        end
        ST_CALC: begin
          // pick the next input, or rest for the remainder of the cycle
          acc_r      <= {(RAW_W+8){1'b0}};
          samp_idx_r <= 8'h00;
          samp_cnt_r <= 32'h0;
          if (next_ok) begin
            in_idx_r   <= next_in;
            meas_input <= next_in;
            meas_start <= 1'b1;
            // retire the chosen input so the next pick moves on
            todo_r     <= todo_r & ~(6'h01 << next_in);
            state_r    <= ST_SAMP;
          end else begin
            low_power <= 1'b1;
            state_r   <= ST_REST;
          end
        end
        ST_SAMP: begin
          // a sample ends: fold it in, then start the next or finish the input
          if (samp_end) begin
            acc_r      <= acc_add;
            samp_cnt_r <= 32'h0;
            samp_idx_r <= samp_idx_r + 8'h01;
            if (samp_last) begin
              state_r <= ST_CALC;
            end else begin
              meas_start <= 1'b1;
            end
          end else begin
            samp_cnt_r <= samp_cnt_r + 32'h1;
          end
        end
        default: begin
          // an overlong sampling phase arrives here already past the period,
          // so it rests one cycle and the sample count wins over the period
          if (!standby_mode) begin
            low_power <= 1'b0;
            state_r   <= ST_IDLE;
          end else if (cyc_cnt_r + 32'h1 >= cycle_len) begin
            low_power <= 1'b0;
            state_r   <= ST_IDLE;
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // combine, scale and classify one finished measurement
  wire             done_meas = (state_r == ST_SAMP) && samp_end && samp_last;
  // averaging divides by the power-of-two count and truncates
  wire [RAW_W+7:0] avg_val   = acc_add >> standby_sample_count;
  // summed mode passes the raw sum, which may wrap below
  wire [RAW_W+7:0] comb_val  = accumulate_not_average ? acc_add : avg_val;
  // msb of 8 bits weighs 128, so 128x gives 64 raw counts and 1x gives 8192
  wire [RAW_W+8:0] scaled    = {comb_val, 1'b0} >> gain_r;
  wire             ovf       = |scaled[RAW_W+8:8];
  // summed mode simply wraps, averaged mode saturates
  wire [7:0]       delta_nxt = (ovf && !accumulate_not_average) ? 8'hff : scaled[7:0];

  // noise threshold per input: active threshold times (code + 2) eighths,
  // that is 25 to 62.5 percent, compared against the scaled delta
  wire [6:0]       act_thr   = active_thresh[in_idx_r*7 +: 7];
  wire [10:0]      noise_prd = act_thr * ({2'b00, noise_pct_sel_r} + `NOISE_PCT_BASE);
  wire [7:0]       noise_thr = noise_prd[10:`NOISE_PCT_SHIFT];
  wire             spike     = (delta_nxt > noise_thr) && (delta_nxt <= {1'b0, act_thr});
  wire             touch_nxt = (delta_nxt > {1'b0, sb_thr_r});

  // result registers; input and delta hold until the next measurement finishes, result_valid pulses one cycle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      result_valid <= 1'b0;
      result_input <= 3'd0;
      result_delta <= 8'h00;
    end else if (ce) begin
      result_valid <= done_meas;
      if (done_meas) begin
        result_input <= in_idx_r;
        result_delta <= delta_nxt;
      end
    end
  end

  // screening outcome, a one-cycle pulse pair beside result_valid;
  // with screening off every result may feed recalibration
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      noise_spike <= 1'b0;
      recal_use   <= 1'b0;
    end else if (ce) begin
      noise_spike <= done_meas & spike & ~noise_screen_disable;
      recal_use   <= done_meas & (~spike | noise_screen_disable);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-input standby touch flags; a result that finishes after standby has
  // ended is dropped, so no stale touch survives the exit
  wire [5:0]       touch_upd;
  wire [5:0]       in_hot    = 6'h01 << in_idx_r;
  genvar           g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_touch
      // clear outside standby, load on this input's result, else hold
      assign touch_upd[g] = !standby_mode             ? 1'b0 :
                            (done_meas && in_hot[g]) ? touch_nxt :
                            standby_touch[g];
    end
  endgenerate

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      standby_touch <= 6'h00;
    end else if (ce) begin
      standby_touch <= touch_upd;
    end
  end

endmodule // standby_sense

// ===== hdl/standby_sense_defines.vh
// register map, field positions, reset values and timing figures
// for the standby sensing and noise screening block; definitions only
`ifndef STANDBY_SENSE_DEFINES_VH
`define STANDBY_SENSE_DEFINES_VH

// register offsets
`define ADDR_NOISE_THRESHOLD_CTRL   8'h38
`define ADDR_STANDBY_INPUT_ENABLE   8'h40
`define ADDR_STANDBY_SENSING_CONFIG 8'h41
`define ADDR_STANDBY_SENSITIVITY    8'h42
`define ADDR_STANDBY_THRESHOLD      8'h43

// reset values
`define RST_NOISE_THRESHOLD_CTRL    8'h01
`define RST_STANDBY_INPUT_ENABLE    8'h00
`define RST_STANDBY_SENSING_CONFIG  8'h39
`define RST_STANDBY_SENSITIVITY     8'h02
`define RST_STANDBY_THRESHOLD       8'h40

// field positions
`define NOISE_PCT_MSB               1
`define NOISE_PCT_LSB               0
`define MON_MSB                     5
`define MON_LSB                     0
`define CFG_ACCUM_BIT               7
`define CFG_COUNT_MSB               6
`define CFG_COUNT_LSB               4
`define CFG_SAMP_MSB                3
`define CFG_SAMP_LSB                2
`define CFG_CYC_MSB                 1
`define CFG_CYC_LSB                 0
`define GAIN_MSB                    2
`define GAIN_LSB                    0
`define THR_MSB                     6
`define THR_LSB                     0

// noise fraction is (code + NOISE_PCT_BASE) eighths of the touch threshold
`define NOISE_PCT_BASE              4'h2
`define NOISE_PCT_SHIFT             3

// timing: shortest sample and shortest cycle, in ns, and the clock rate
`define CLK_MHZ                     250
`define SAMP_T0_NS                  320000
`define CYCLE_T0_NS                 35000000

`endif

// ===== verif/afe_model.sv
// stand-in for the analog front end: a fixed count per input
// assumes: meas_start and meas_input come from the sequencer
`timescale 1ns/1ps
module afe_model (
  input  wire        meas_start,
  input  wire [2:0]  meas_input,
  input  wire [95:0] level,
  output reg  [15:0] afe_count
);
  initial afe_count = 16'h0000;
  // count settles as each sample starts and holds through it
  always @(posedge meas_start) afe_count = level[16*meas_input +: 16];
endmodule // afe_model

// ===== verif/standby_sense_asserts.sv
// port checks for the standby sensing block
// assumes: bound to standby_sense; one clock, async active-high reset
`timescale 1ns/1ps
module standby_sense_asserts (
  input wire        clk, rst, ce, reg_wr, standby_mode, noise_screen_disable,
  input wire [41:0] active_thresh,
  input wire [7:0]  reg_addr, reg_wdata, result_delta,
  input wire        meas_start, low_power, result_valid, noise_spike, recal_use,
  input wire [2:0]  meas_input, result_input,
  input wire [5:0]  standby_touch
);
  reg  [1:0] nc_r;
  reg  [5:0] en_r;
  reg  [6:0] thr_r;
  wire [6:0] act  = active_thresh[result_input*7 +: 7];
  wire [9:0] prod = act * ({8'h00, nc_r} + 10'h002);
  wire       win  = result_delta > prod[9:3] && result_delta <= act;
  // shadow of the registers the checks depend on
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      nc_r <= 2'h1;
      en_r <= 6'h00;
      thr_r <= 7'h40;
    end else if (ce && reg_wr) begin
      if (reg_addr == 8'h38) nc_r <= reg_wdata[1:0];
      if (reg_addr == 8'h40) en_r <= reg_wdata[5:0];
      if (reg_addr == 8'h43) thr_r <= reg_wdata[6:0];
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_spike_exact: assert property (result_valid && !noise_screen_disable |-> noise_spike == win)
    else $error("noise spike flag wrong");
  a_screen_off: assert property (result_valid && noise_screen_disable |-> recal_use)
    else $error("screen disable ignored");
  a_recal_split: assert property (result_valid |-> recal_use == !noise_spike)
    else $error("recal use not inverse of spike");
  a_start_enabled: assert property (meas_start |-> en_r[meas_input])
    else $error("sample on disabled input");
  a_result_enabled: assert property (result_valid |-> en_r[result_input])
    else $error("result for disabled input");
  a_touch_thr: assert property (result_valid |-> standby_touch[result_input] == (result_delta > thr_r))
    else $error("touch flag wrong");
  a_touch_clear: assert property (!standby_mode |=> standby_touch == 6'h00)
    else $error("touch kept outside standby");
  a_sample_gap: assert property (meas_start |=> !meas_start [*3])
    else $error("sample too short");
  a_rest_quiet: assert property (low_power |-> !meas_start && !result_valid)
    else $error("activity during rest");
endmodule // standby_sense_asserts

bind standby_sense standby_sense_asserts i_chk (.*);

// ===== verif/test_standby_sense.sv
// self-checking bench for the standby sensing block
// assumes: afe_model as front end; shortened sample and cycle bases
`timescale 1ns/1ps
module test_standby_sense;
  reg         clk, rst, ce, standby_mode, noise_screen_disable, reg_wr, reg_rd, acc, sp;
  reg  [41:0] active_thresh;
  reg  [95:0] level;
  reg  [7:0]  reg_addr, reg_wdata, d, nt;
  reg  [6:0]  thr, a;
  reg  [5:0]  en;
  reg  [2:0]  cnt, gain;
  reg  [1:0]  nc, samp, cyc;
  wire [15:0] afe_count;
  wire [7:0]  reg_rdata, result_delta;
  wire [5:0]  standby_touch;
  wire [2:0]  meas_input, result_input;
  wire        meas_start, low_power, result_valid, noise_spike, recal_use;
  integer     err_count, checks_done, seed, i, t, n, k, ne, t0, lo, hi;
  standby_sense #(.SAMP_BASE_CYC(4), .CYCLE_BASE_CYC(200)) i_dut (.*);
  afe_model i_afe (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task step; @(posedge clk) #1; endtask
  task summarize;
    begin
      $display("errors %0d checks %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [7:0] g, input [7:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        err_count = err_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task tmo;
    if (k >= 4000) begin
      err_count = err_count + 1;
      summarize;
    end
  endtask
  task wr(input [7:0] ad, input [7:0] v);
    begin
      step;
      reg_addr = ad;
      reg_wdata = v;
      reg_wr = 1'b1;
      step;
      reg_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] ad, input [7:0] e);
    begin
      step;
      reg_addr = ad;
      reg_rd = 1'b1;
      step;
      reg_rd = 1'b0;
      chk(reg_rdata, e);
    end
  endtask
  // scaled delta for a steady count: sum or average, then gain shift
  function [7:0] exp_delta(input [15:0] c);
    reg [31:0] v;
    begin
      v = acc ? ({16'h0000, c} << cnt) : {16'h0000, c};
      v = (v << 1) >> gain;
      exp_delta = (!acc && v > 32'h000000ff) ? 8'hff : v[7:0];
    end
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    seed = 39408;
    err_count = 0;
    checks_done = 0;
    {ce, standby_mode, noise_screen_disable, reg_wr, reg_rd} = 5'b10000;
    {reg_addr, reg_wdata, active_thresh, level} = 0;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    for (i = 0; i < 5; i = i + 1) rd(ADS(i), RVS(i));
    ce = 1'b0;
    wr(8'h38, 8'h03);
    ce = 1'b1;
    rd(8'h38, 8'h01);
    for (i = 0; i < 5; i = i + 1) begin
      wr(ADS(i), 8'hff);
      rd(ADS(i), MSK(i));
    end
    wr(8'h44, 8'ha5);
    rd(8'h44, 8'h00);
    for (t = 0; t < 10; t = t + 1) begin
      en = (t == 0) ? 6'h3f : $random(seed);
      if (en == 6'h00) en = 6'h21;
      cnt = (t == 0) ? 3'h2 : {$random(seed)} % 3;
      samp = (t == 0) ? 2'h2 : (t == 9) ? 2'h3 : {$random(seed)} % 2;
      cyc = t[2:1];
      nc = t[1:0];
      gain = t[2:0];
      acc = (t == 0 || t == 7 || t == 8) ? 1'b0 : $random(seed);
      thr = $random(seed);
      noise_screen_disable = $random(seed);
      active_thresh = {$random(seed), $random(seed)};
      for (i = 0; i < 6; i = i + 1)
        level[16*i +: 16] = (t == 0) ? 16'h0040 : (t == 7) ? 16'h2000 :
                            (t == 8) ? 16'h0100 : $random(seed) & 16'h007f;
      wr(8'h38, {6'h00, nc});
      wr(8'h40, {2'h0, en});
      wr(8'h41, {acc, cnt, samp, cyc});
      wr(8'h42, {5'h00, gain});
      wr(8'h43, {1'b0, thr});
      standby_mode = 1'b1;
      t0 = -1;
      ne = 0;
      for (i = 0; i < 6; i = i + 1) begin
        if (!en[i]) continue;
        n = 0;
        k = 0;
        while (result_valid !== 1'b1 && k < 4000) begin
          if (meas_start === 1'b1) n = n + 1;
          if (meas_start === 1'b1 && t0 < 0) t0 = $time;
          step;
          k = k + 1;
        end
        tmo;
        ne = ne + 1;
        a = active_thresh[7*i +: 7];
        d = exp_delta(level[16*i +: 16]);
        nt = ({3'h0, a} * (nc + 10'h002)) >> 3;
        sp = d > nt && d <= a;
        chk(n[7:0], 8'h01 << cnt);
        chk({5'h00, result_input}, i[7:0]);
        chk(result_delta, d);
        chk({6'h00, noise_spike, recal_use}, {6'h00, sp & !noise_screen_disable, !sp | noise_screen_disable});
        chk({7'h00, standby_touch[i]}, {7'h00, d > thr});
        step;
      end
      k = 0;
      sp = 1'b0;
      while (meas_start !== 1'b1 && k < 4000) begin
        if (low_power === 1'b1) sp = 1'b1;
        step;
        k = k + 1;
      end
      tmo;
      chk({7'h00, sp}, 8'h01);
      lo = 200 * (cyc + 1);
      k = ne * (4 << samp) * (1 << cnt);
      hi = ((k + 3 * ne > lo) ? k + 3 * ne : lo) + 6;
      n = ($time - t0) / 4;
      chk({7'h00, n >= lo && n >= k && n <= hi}, 8'h01);
      standby_mode = 1'b0;
      step;
      step;
      chk({2'h0, standby_touch}, 8'h00);
      rst = 1'b1;
      step;
      rst = 1'b0;
    end
    summarize;
  end
  function [7:0] ADS(input integer j); ADS = 8'h38 + ((j == 0) ? 8'h00 : 8'h07 + j[7:0]); endfunction
  function [7:0] RVS(input integer j); RVS = (40'h0100390240 >> (32 - 8 * j)); endfunction
  function [7:0] MSK(input integer j); MSK = (40'h033fff077f >> (32 - 8 * j)); endfunction
endmodule // test_standby_sense
